// ==== rtl/cbu_consts.svh ====
/*
  constants of the conditional branch unit: opcodes, prefix, sub-opcodes, forced pc high byte and state counts.
  assumes inclusion by the package and the design files through its bare name.
*/
`ifndef CBU_CONSTS_SVH
`define CBU_CONSTS_SVH

`define CBU_ESC_PREFIX      8'hA5
`define CBU_OP_EXT_BIT      8'hA9
`define CBU_OP_BITCLR_S     8'h10
`define CBU_OP_CARRY        8'h40
`define CBU_OP_EQUAL        8'hA8
`define CBU_OP_GREATER      8'h38
`define CBU_OP_LESS_EQ      8'h28
`define CBU_OP_INDIRECT     8'h73
`define CBU_OP_BIT_CLEAR    8'h30
`define CBU_OP_NO_CARRY     8'h50
`define CBU_OP_NOT_EQUAL    8'h78
`define CBU_SUB_BITCLR_HI   5'h02
`define CBU_SUB_BIT_CLR_HI  5'h06
`define CBU_PC_HIGH_FORCE   8'hFF
`define CBU_TAKEN_EXTRA     3'h3
`define CBU_INDIRECT_STATES 3'h5

`endif

// ==== rtl/cbu_pkg.sv ====
/*
  types shared by the conditional branch unit.
  assumes cbu_consts.svh is on the include path.
*/
package cbu_pkg;
  `include "cbu_consts.svh"

  typedef enum logic [3:0] {
    CBU_K_NONE     = 4'h0,
    CBU_K_BITCLR   = 4'h1,
    CBU_K_CARRY    = 4'h2,
    CBU_K_EQUAL    = 4'h3,
    CBU_K_GREATER  = 4'h4,
    CBU_K_LESS_EQ  = 4'h5,
    CBU_K_INDIRECT = 4'h6,
    CBU_K_BIT_CLR  = 4'h7,
    CBU_K_NO_CARRY = 4'h8,
    CBU_K_NOT_EQ   = 4'h9
  } cbu_kind_t;

  typedef enum logic [1:0] {
    CBU_S_IDLE = 2'b00,
    CBU_S_BUSY = 2'b01
  } cbu_state_t;
endpackage

// ==== rtl/cbu_decode.sv ====
/*
  opcode decoder of the conditional branch unit: kind, length and base state count.
  assumes the bytes arrive in fetch order on the same clock.
*/
`include "cbu_consts.svh"
module cbu_decode
  import cbu_pkg::*;
(
  input  wire logic              mode_source_in,
  input  wire logic              prefix_in,
  input  wire logic [7:0]        op_in,
  input  wire logic [7:0]        op2_in,
  output cbu_pkg::cbu_kind_t     kind_out,
  output logic      [2:0]        length_out,
  output logic      [2:0]        base_states_out,
  output logic                   legal_out
);
  logic esc_ok;
  logic ext_pair;

  always_comb begin
    // prefix needed in binary mode, forbidden in source mode
    esc_ok   = (prefix_in != mode_source_in);
    ext_pair = (op_in == `CBU_OP_EXT_BIT) && esc_ok;
    kind_out        = CBU_K_NONE;
    length_out      = 3'h2;
    base_states_out = 3'h1;
    legal_out       = 1'b1;
    if (ext_pair && op2_in[7:3] == `CBU_SUB_BITCLR_HI) begin
      kind_out        = CBU_K_BITCLR;
      length_out      = mode_source_in ? 3'h4 : 3'h5;
      base_states_out = mode_source_in ? 3'h3 : 3'h4;
    end else if (ext_pair && op2_in[7:3] == `CBU_SUB_BIT_CLR_HI) begin
      kind_out        = CBU_K_BIT_CLR;
      length_out      = mode_source_in ? 3'h4 : 3'h5;
      base_states_out = mode_source_in ? 3'h3 : 3'h4;
    end else if (!prefix_in && op_in == `CBU_OP_BITCLR_S) begin
      kind_out        = CBU_K_BITCLR;
      length_out      = 3'h3;
      base_states_out = 3'h4;
    end else if (!prefix_in && op_in == `CBU_OP_BIT_CLEAR) begin
      kind_out        = CBU_K_BIT_CLR;
      length_out      = 3'h3;
      base_states_out = 3'h2;
    end else if (!prefix_in && op_in == `CBU_OP_CARRY) begin
      kind_out = CBU_K_CARRY;
    end else if (!prefix_in && op_in == `CBU_OP_NO_CARRY) begin
      kind_out = CBU_K_NO_CARRY;
    end else if (!prefix_in && op_in == `CBU_OP_INDIRECT) begin
      kind_out        = CBU_K_INDIRECT;
      length_out      = 3'h1;
      base_states_out = `CBU_INDIRECT_STATES;
    end else if (esc_ok && (op_in == `CBU_OP_EQUAL || op_in == `CBU_OP_GREATER ||
                 op_in == `CBU_OP_LESS_EQ || op_in == `CBU_OP_NOT_EQUAL)) begin
      length_out      = mode_source_in ? 3'h2 : 3'h3;
      base_states_out = mode_source_in ? 3'h1 : 3'h2;
      if (op_in == `CBU_OP_EQUAL) begin
        kind_out = CBU_K_EQUAL;
      end else if (op_in == `CBU_OP_GREATER) begin
        kind_out = CBU_K_GREATER;
      end else if (op_in == `CBU_OP_LESS_EQ) begin
        kind_out = CBU_K_LESS_EQ;
      end else begin
        kind_out = CBU_K_NOT_EQ;
      end
    end else begin
      legal_out = 1'b0;
    end
  end
endmodule // cbu_decode

// ==== rtl/cbu_branch_unit.sv ====
/*
  execute-stage branch unit for conditional, bit-test and indirect jumps.
  assumes the core presents one decoded instruction per start pulse with its
  operand bytes, flags, tested bit, accumulator and data pointer held stable.
*/
// Contract
// - advance pc past instruction, then add displacement
// - binary mode needs escape prefix for some
// - bit-set-clear jump clears set bit, branches
// - carry jump branches only when carry set
// - carry jump two bytes, 1 or 4 states
// - equal jump branches on zero flag set
// - greater jump needs zero and carry clear
// - less-equal jump on zero or carry set
// - indirect jump pc low = accumulator plus pointer
// - indirect jump forces pc high byte to ones
// - bit-clear jump branches on zero, bit kept
// - bit-clear jump short and extended forms
// - no-carry jump branches on carry clear
// - not-equal jump branches on zero flag clear
// - not-equal jump opcode 78, prefixed in binary
`include "cbu_consts.svh"
module cbu_branch_unit
  import cbu_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic        start_in,
  input  wire logic        mode_source_in,
  input  wire logic        prefix_in,
  input  wire logic [7:0]  op_in,
  input  wire logic [7:0]  op2_in,
  input  wire logic [7:0]  rel_in,
  input  wire logic [23:0] pc_in,
  input  wire logic        carry_flag_in,
  input  wire logic        zero_flag_in,
  input  wire logic        bit_value_in,
  input  wire logic [7:0]  accum_in,
  input  wire logic [15:0] data_pointer_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             illegal_out,
  output logic             taken_out,
  output logic [23:0]      pc_out,
  output logic             bit_clear_out,
  output logic [2:0]       bit_index_out,
  output logic [2:0]       states_out
);
  import cbu_pkg::*;

  cbu_kind_t  kind;
  logic [2:0] length;
  logic [2:0] base_states;
  logic       legal;
  logic       cond;
  logic [23:0] seq_pc;
  logic [23:0] target;

  cbu_state_t  state, next_state;
  logic [2:0]  count, next_count;
  logic        done, next_done;
  logic        illegal, next_illegal;
  logic        taken, next_taken;
  logic [23:0] pc, next_pc;
  logic        bit_clear, next_bit_clear;
  logic [2:0]  bit_index, next_bit_index;
  logic [2:0]  states, next_states;

  cbu_decode u_decode (
    .mode_source_in  (mode_source_in),
    .prefix_in       (prefix_in),
    .op_in           (op_in),
    .op2_in          (op2_in),
    .kind_out        (kind),
    .length_out      (length),
    .base_states_out (base_states),
    .legal_out       (legal)
  );

  always_comb begin
    unique case (kind)
      CBU_K_BITCLR:   cond = bit_value_in;
      CBU_K_BIT_CLR:  cond = !bit_value_in;
      CBU_K_CARRY:    cond = carry_flag_in;
      CBU_K_NO_CARRY: cond = !carry_flag_in;
      CBU_K_EQUAL:    cond = zero_flag_in;
      CBU_K_NOT_EQ:   cond = !zero_flag_in;
      CBU_K_GREATER:  cond = !zero_flag_in && !carry_flag_in;
      CBU_K_LESS_EQ:  cond = zero_flag_in || carry_flag_in;
      CBU_K_INDIRECT: cond = 1'b1;
      default:        cond = 1'b0;
    endcase
    seq_pc = pc_in + {21'h000000, length};
    target = seq_pc + {{16{rel_in[7]}}, rel_in};
  end

  always_comb begin
    next_state     = state;
    next_count     = count;
    next_done      = 1'b0;
    next_illegal   = illegal;
    next_taken     = taken;
    next_pc        = pc;
    next_bit_clear = 1'b0;
    next_bit_index = bit_index;
    next_states    = states;
    unique case (state)
      CBU_S_IDLE: begin
        if (start_in) begin
          next_illegal = !legal;
          next_taken   = legal && cond;
          next_bit_index = op2_in[2:0];
          if (!legal) begin
            next_pc     = pc_in;
            next_states = 3'h1;
          end else if (kind == CBU_K_INDIRECT) begin
            // accumulator and pointer are only read
            next_pc = {`CBU_PC_HIGH_FORCE,
                       data_pointer_in + {8'h00, accum_in}};
            next_states = base_states;
          end else begin
            next_pc     = cond ? target : seq_pc;
            next_states = cond ? base_states + `CBU_TAKEN_EXTRA : base_states;
            next_bit_clear = (kind == CBU_K_BITCLR) && cond;
          end
          next_count = 3'h1;
          next_state = CBU_S_BUSY;
          if ((legal ? (cond && kind != CBU_K_INDIRECT ? base_states + `CBU_TAKEN_EXTRA
                        : base_states) : 3'h1) == 3'h1) begin
            next_state = CBU_S_IDLE;
            next_done  = 1'b1;
          end
        end
      end
      CBU_S_BUSY: begin
        next_count = count + 3'h1;
        if (next_count == states) begin
          next_state = CBU_S_IDLE;
          next_done  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state     <= CBU_S_IDLE;
      count     <= 3'h0;
      done      <= 1'b0;
      illegal   <= 1'b0;
      taken     <= 1'b0;
      pc        <= 24'h000000;
      bit_clear <= 1'b0;
      bit_index <= 3'h0;
      states    <= 3'h0;
    end else begin
      state     <= next_state;
      count     <= next_count;
      done      <= next_done;
      illegal   <= next_illegal;
      taken     <= next_taken;
      pc        <= next_pc;
      bit_clear <= next_bit_clear;
      bit_index <= next_bit_index;
      states    <= next_states;
    end
  end

  // flags never driven: the unit has no carry or zero flag outputs
  assign busy_out      = (state == CBU_S_BUSY);
  assign done_out      = done;
  assign illegal_out   = illegal;
  assign taken_out     = taken;
  assign pc_out        = pc;
  assign bit_clear_out = bit_clear;
  assign bit_index_out = bit_index;
  assign states_out    = states;

  carry_branch_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !prefix_in && op_in == `CBU_OP_CARRY
    |=> taken_out == $past(carry_flag_in) && states_out == ($past(carry_flag_in) ? 3'h4 : 3'h1))
    else $error("carry jump outcome wrong");

  carry_pc_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !prefix_in && op_in == `CBU_OP_NO_CARRY && carry_flag_in
    |=> pc_out == $past(pc_in) + 24'h000002 && !taken_out)
    else $error("no-carry jump pc wrong");

  rel_target_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && mode_source_in && !prefix_in && op_in == `CBU_OP_EQUAL
    && zero_flag_in
    |=> pc_out == $past(pc_in) + 24'h000002 + {{16{$past(rel_in[7])}}, $past(rel_in)})
    else $error("equal jump target wrong");

  prefix_need_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !mode_source_in && !prefix_in && op_in == `CBU_OP_GREATER
    |=> illegal_out && !taken_out)
    else $error("binary mode accepted unprefixed opcode");

  ule_cond_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && legal && kind == CBU_K_LESS_EQ
    |=> taken_out == ($past(zero_flag_in) || $past(carry_flag_in)))
    else $error("less-equal condition wrong");

  ugt_cond_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && legal && kind == CBU_K_GREATER
    |=> taken_out == (!$past(zero_flag_in) && !$past(carry_flag_in)))
    else $error("greater condition wrong");

  indirect_pc_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && legal && kind == CBU_K_INDIRECT
    |=> pc_out[23:16] == 8'hFF && states_out == 3'h5 && busy_out ##3 busy_out ##1 done_out)
    else $error("indirect jump wrong");

  bit_clear_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    bit_clear_out |-> taken_out && $past(bit_value_in))
    else $error("bit cleared without being set");

  bit_keep_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && legal && kind == CBU_K_BIT_CLR
    |=> !bit_clear_out && taken_out == !$past(bit_value_in))
    else $error("bit-clear jump wrong");

  carry_target_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !prefix_in && op_in == `CBU_OP_CARRY && carry_flag_in
    |=> pc_out == $past(pc_in) + 24'h000002 + {{16{$past(rel_in[7])}}, $past(rel_in)})
    else $error("carry jump target wrong");

  carry_states_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !prefix_in && op_in == `CBU_OP_CARRY && carry_flag_in
    |=> busy_out ##2 busy_out ##1 done_out && !busy_out)
    else $error("taken carry jump not four states");

  ext_setclr_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && op_in == `CBU_OP_EXT_BIT && prefix_in != mode_source_in
    && op2_in[7:3] == `CBU_SUB_BITCLR_HI
    |=> !illegal_out && bit_clear_out == $past(bit_value_in)
    && bit_index_out == $past(op2_in[2:0])
    && states_out == ($past(mode_source_in) ? 3'h3 : 3'h4)
                     + ($past(bit_value_in) ? 3'h3 : 3'h0))
    else $error("extended bit-set-clear jump wrong");

  setclr_short_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !prefix_in && op_in == `CBU_OP_BITCLR_S
    |=> pc_out == $past(pc_in) + 24'h000003
        + ($past(bit_value_in) ? {{16{$past(rel_in[7])}}, $past(rel_in)} : 24'h000000))
    else $error("bit-set-clear jump pc wrong");

  equal_cond_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && legal && kind == CBU_K_EQUAL
    |=> taken_out == $past(zero_flag_in))
    else $error("equal condition wrong");

  equal_count_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !mode_source_in && prefix_in && op_in == `CBU_OP_EQUAL
    && !zero_flag_in
    |=> pc_out == $past(pc_in) + 24'h000003 && states_out == 3'h2)
    else $error("binary equal jump length or states wrong");

  ugt_count_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !mode_source_in && prefix_in && op_in == `CBU_OP_GREATER
    && zero_flag_in
    |=> !taken_out && pc_out == $past(pc_in) + 24'h000003 && states_out == 3'h2)
    else $error("binary greater jump length or states wrong");

  ule_count_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !mode_source_in && prefix_in && op_in == `CBU_OP_LESS_EQ
    && carry_flag_in
    |=> taken_out && states_out == 3'h5)
    else $error("binary less-equal jump states wrong");

  indirect_low_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && legal && kind == CBU_K_INDIRECT
    |=> taken_out && pc_out[15:0] == $past(data_pointer_in) + {8'h00, $past(accum_in)})
    else $error("indirect jump low address wrong");

  bitclr_pc_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !prefix_in && op_in == `CBU_OP_BIT_CLEAR && bit_value_in
    |=> !taken_out && pc_out == $past(pc_in) + 24'h000003)
    else $error("bit-clear jump pc wrong");

  bitclr_short_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !prefix_in && op_in == `CBU_OP_BIT_CLEAR
    |=> states_out == ($past(bit_value_in) ? 3'h2 : 3'h5))
    else $error("short bit-clear jump states wrong");

  bitclr_ext_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !mode_source_in && prefix_in && op_in == `CBU_OP_EXT_BIT
    && op2_in[7:3] == `CBU_SUB_BIT_CLR_HI && !bit_value_in
    |=> taken_out && !bit_clear_out && states_out == 3'h7)
    else $error("extended bit-clear jump wrong");

  nocarry_count_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && !prefix_in && op_in == `CBU_OP_NO_CARRY && !carry_flag_in
    |=> taken_out && states_out == 3'h4
    && pc_out == $past(pc_in) + 24'h000002 + {{16{$past(rel_in[7])}}, $past(rel_in)})
    else $error("taken no-carry jump wrong");

  noteq_cond_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && legal && kind == CBU_K_NOT_EQ
    |=> taken_out == !$past(zero_flag_in))
    else $error("not-equal condition wrong");

  noteq_pc_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    start_in && !busy_out && mode_source_in && !prefix_in && op_in == `CBU_OP_NOT_EQUAL
    && zero_flag_in
    |=> !illegal_out && !taken_out && pc_out == $past(pc_in) + 24'h000002)
    else $error("source not-equal jump pc wrong");
endmodule // cbu_branch_unit

// ==== dv/cbu_branch_unit_tb.sv ====
/*
  self-checking bench of the conditional branch unit: corner cases, then seeded random jumps.
  assumes the design files and cbu_consts.svh are compiled first.
*/
module cbu_branch_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cbu_pkg::*;
  `include "cbu_consts.svh"

  logic        mclk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        start_in = 1'b0;
  logic        mode_source_in = 1'b0;
  logic        prefix_in = 1'b0;
  logic [7:0]  op_in = 8'h00;
  logic [7:0]  op2_in = 8'h00;
  logic [7:0]  rel_in = 8'h00;
  logic [23:0] pc_in = 24'h000000;
  logic        carry_flag_in = 1'b0;
  logic        zero_flag_in = 1'b0;
  logic        bit_value_in = 1'b0;
  logic [7:0]  accum_in = 8'h00;
  logic [15:0] data_pointer_in = 16'h0000;
  logic        busy_out, done_out, illegal_out, taken_out, bit_clear_out;
  logic [23:0] pc_out;
  logic [2:0]  bit_index_out, states_out;
  int          fails = 0;
  int          compares = 0;
  logic [7:0]  ops [11] = '{8'h40, 8'h50, 8'h30, 8'h10, 8'hA8, 8'h38, 8'h28, 8'h78, 8'h73,
                            8'hA9, 8'hA9};

  cbu_branch_unit cbu_branch_unit_inst (.mclk_in(mclk_in), .srst_in(srst_in),
    .start_in(start_in), .mode_source_in(mode_source_in), .prefix_in(prefix_in),
    .op_in(op_in), .op2_in(op2_in), .rel_in(rel_in), .pc_in(pc_in),
    .carry_flag_in(carry_flag_in), .zero_flag_in(zero_flag_in), .bit_value_in(bit_value_in),
    .accum_in(accum_in), .data_pointer_in(data_pointer_in), .busy_out(busy_out),
    .done_out(done_out), .illegal_out(illegal_out), .taken_out(taken_out), .pc_out(pc_out),
    .bit_clear_out(bit_clear_out), .bit_index_out(bit_index_out), .states_out(states_out));

  always #12.5 mclk_in = ~mclk_in;

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      fails++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // legality, outcome, byte length and untaken state count of one instruction
  function automatic void predict(input logic [7:0] op, o2, input logic md, pf, c, z, b,
                                  output logic lg, tk, output logic [2:0] ln, bs);
    lg = !pf;
    tk = 1'b0;
    ln = 3'h2;
    bs = 3'h1;
    case (op)
      `CBU_OP_CARRY:     tk = c;
      `CBU_OP_NO_CARRY:  tk = !c;
      `CBU_OP_BITCLR_S:  begin tk = b; ln = 3'h3; bs = 3'h4; end
      `CBU_OP_BIT_CLEAR: begin tk = !b; ln = 3'h3; bs = 3'h2; end
      // always taken, five states in all
      `CBU_OP_INDIRECT:  begin tk = 1'b1; ln = 3'h1; bs = 3'h2; end
      `CBU_OP_EQUAL, `CBU_OP_GREATER, `CBU_OP_LESS_EQ, `CBU_OP_NOT_EQUAL: begin
        lg = (pf == !md);
        ln = md ? 3'h2 : 3'h3;
        bs = md ? 3'h1 : 3'h2;
        tk = (op == `CBU_OP_EQUAL) ? z : (op == `CBU_OP_GREATER) ? (!z && !c) :
             (op == `CBU_OP_LESS_EQ) ? (z || c) : !z;
      end
      `CBU_OP_EXT_BIT: begin
        lg = (pf == !md) && (o2[7:3] == `CBU_SUB_BITCLR_HI || o2[7:3] == `CBU_SUB_BIT_CLR_HI);
        tk = (o2[7:3] == `CBU_SUB_BITCLR_HI) ? b : !b;
        ln = md ? 3'h4 : 3'h5;
        bs = md ? 3'h3 : 3'h4;
      end
      default: lg = 1'b0;
    endcase
  endfunction

  task automatic run(input string name, input logic [23:0] pc, input logic [7:0] op, o2, r,
                     input logic md, pf, c, z, b);
    logic        lg, tk, clr, seen;
    logic [2:0]  ln, bs, st;
    logic [23:0] epc;
    int          n;
    predict(op, o2, md, pf, c, z, b, lg, tk, ln, bs);
    st = lg ? bs + (tk ? `CBU_TAKEN_EXTRA : 3'h0) : 3'h1;
    clr = lg && tk && (op == `CBU_OP_BITCLR_S ||
          (op == `CBU_OP_EXT_BIT && o2[7:3] == `CBU_SUB_BITCLR_HI));
    epc = !lg ? pc : (op == `CBU_OP_INDIRECT) ?
          {`CBU_PC_HIGH_FORCE, data_pointer_in + {8'h00, accum_in}} :
          pc + 24'(ln) + (tk ? {{16{r[7]}}, r} : 24'h000000);
    @(negedge mclk_in);
    {pc_in, op_in, op2_in, rel_in} = {pc, op, o2, r};
    {mode_source_in, prefix_in, carry_flag_in, zero_flag_in, bit_value_in} = {md, pf, c, z, b};
    start_in = 1'b1;
    seen = 1'b0;
    for (n = 1; n <= 8 && !seen; n++) begin
      @(negedge mclk_in);
      start_in = 1'b0;
      if (n == 1) begin
        check(illegal_out === !lg, "illegal flag");
        check(pc_out === epc, "next pc");
        check(states_out === st, "state count");
        check(!lg || taken_out === tk, "taken flag");
        check(bit_clear_out === clr, "bit clear pulse");
        check(bit_index_out === o2[2:0], "bit index");
        check(busy_out === (st > 3'h1), "busy level");
      end
      if (n == 2) check(bit_clear_out === 1'b0, "bit clear width");
      if (done_out === 1'b1) begin
        seen = 1'b1;
        check(n == int'(st) && busy_out === 1'b0, "done timing");
      end
    end
    check(seen, "done missing");
    $display("test %s done", name);
  endtask

  initial begin
    #500000;
    fails++;
    print_verdict();
  end

  initial begin
    logic [7:0] op;
    logic       md, pf;
    void'($urandom(32'h9006));
    repeat (10) @(posedge mclk_in);
    @(negedge mclk_in);
    srst_in = 1'b0;
    #1;
    check({busy_out, done_out, taken_out, pc_out} === 27'h0, "reset values");
    run("carry taken", 24'h000100, `CBU_OP_CARRY, 8'h00, 8'h04, 0, 0, 1, 0, 0);
    run("carry not", 24'h000100, `CBU_OP_CARRY, 8'h00, 8'h04, 1, 0, 0, 1, 1);
    run("nocarry", 24'h00F000, `CBU_OP_NO_CARRY, 8'h00, 8'h80, 0, 0, 0, 0, 0);
    run("nocarry not", 24'h00F000, `CBU_OP_NO_CARRY, 8'h00, 8'h80, 1, 0, 1, 0, 0);
    run("equal bin", 24'h001000, `CBU_OP_EQUAL, 8'h00, 8'hF0, 0, 1, 0, 1, 0);
    run("equal src", 24'h001000, `CBU_OP_EQUAL, 8'h00, 8'h10, 1, 0, 1, 0, 1);
    run("greater", 24'h002000, `CBU_OP_GREATER, 8'h00, 8'h22, 0, 1, 0, 0, 0);
    run("greater cy", 24'h002000, `CBU_OP_GREATER, 8'h00, 8'h22, 1, 0, 1, 0, 0);
    run("less eq", 24'h003000, `CBU_OP_LESS_EQ, 8'h00, 8'hFE, 0, 1, 1, 0, 0);
    run("less eq not", 24'h003000, `CBU_OP_LESS_EQ, 8'h00, 8'hFE, 1, 0, 0, 0, 1);
    run("not equal", 24'h004000, `CBU_OP_NOT_EQUAL, 8'h00, 8'h81, 0, 1, 0, 0, 0);
    run("not eq z", 24'h004000, `CBU_OP_NOT_EQUAL, 8'h00, 8'h81, 1, 0, 1, 1, 0);
    accum_in = 8'h02;
    data_pointer_in = 16'hFFFF;
    run("indirect", 24'h123456, `CBU_OP_INDIRECT, 8'h00, 8'h00, 0, 0, 1, 1, 1);
    run("setclr one", 24'h000200, `CBU_OP_BITCLR_S, 8'h05, 8'h08, 0, 0, 0, 0, 1);
    run("setclr zero", 24'h000200, `CBU_OP_BITCLR_S, 8'h05, 8'h08, 1, 0, 0, 0, 0);
    run("ext setclr", 24'h000300, `CBU_OP_EXT_BIT, 8'h15, 8'hF8, 0, 1, 0, 0, 1);
    run("ext setclr s", 24'h000300, `CBU_OP_EXT_BIT, 8'h17, 8'hF8, 1, 0, 0, 0, 0);
    run("bitclr", 24'h000400, `CBU_OP_BIT_CLEAR, 8'h02, 8'h40, 0, 0, 1, 1, 0);
    run("bitclr set", 24'h000400, `CBU_OP_BIT_CLEAR, 8'h02, 8'h40, 0, 0, 1, 1, 1);
    run("ext bitclr", 24'h000500, `CBU_OP_EXT_BIT, 8'h33, 8'h06, 1, 0, 0, 0, 0);
    run("ext bitclr b", 24'h000500, `CBU_OP_EXT_BIT, 8'h36, 8'h06, 0, 1, 0, 0, 1);
    run("no prefix", 24'h000600, `CBU_OP_EQUAL, 8'h00, 8'h10, 0, 0, 0, 1, 0);
    run("bad sub", 24'h000600, `CBU_OP_EXT_BIT, 8'h40, 8'h10, 0, 1, 0, 0, 1);
    run("unknown", 24'h000600, 8'h00, 8'h00, 8'h10, 0, 0, 0, 0, 0);
    run("pc wrap", 24'hFFFFFE, `CBU_OP_CARRY, 8'h00, 8'h7F, 0, 0, 1, 0, 0);
    repeat (150) begin
      op = ops[$urandom_range(10)];
      md = 1'($urandom);
      pf = (op == `CBU_OP_EQUAL || op == `CBU_OP_GREATER || op == `CBU_OP_LESS_EQ ||
            op == `CBU_OP_NOT_EQUAL || op == `CBU_OP_EXT_BIT) ? !md : 1'b0;
      if ($urandom_range(7) == 0) pf = !pf;
      accum_in = 8'($urandom);
      data_pointer_in = 16'($urandom);
      run("random", 24'($urandom), op, {2'h0, 1'($urandom), 2'h2, 3'($urandom)},
          8'($urandom), md, pf, 1'($urandom), 1'($urandom), 1'($urandom));
    end
    print_verdict();
  end
endmodule // cbu_branch_unit_tb
